// ===== verilog/orip_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "orip_cfg.svh"

// Overview of operation
// - an 8-bit threshold, reset 0xF2, sets the magnitude at or above which a channel flags.
// - the four over-range pins are driven only while enable bit 3 is set, else low.
// - each pin pulse lasts at least 4*2^exp sampling cycles, exp in bits 2:0, reset 7.
// - startup status bit 0 reads 1 once initialization is done, other bits read zero.
// - profile b takes 0x06 for low power and 0x0F (reset) for high performance.
// - profile c takes 0x00 for low power and 0x04 (reset) for high performance.
// - profile d is an 8-bit read/write field resetting to 0x1B.
// - profile d takes 0x14 for low power and 0x1B for high performance.
module orip_regs
	import orip_pkg::*;
#(
	parameter int CHANNELS   = 4,
	parameter int SAMPLE_W   = 9,
	parameter int ADDR_W     = 10
) (
	input  wire logic                         clk,
	input  wire logic                         arst_n,
	input  wire logic                         sample_valid,
	input  wire logic [CHANNELS*SAMPLE_W-1:0] sample_mag,
	input  wire logic                         init_finished,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	input  wire logic [ADDR_W-1:0]            reg_addr,
	input  wire logic [7:0]                   reg_wdata,
	output logic      [7:0]                   reg_rdata,
	output logic                              reg_rvalid,
	output logic      [CHANNELS-1:0]          overrange_out,
	output logic      [7:0]                   power_code_b,
	output logic      [7:0]                   power_code_c,
	output logic      [7:0]                   power_code_d,
	output orip_mode_type                     power_mode,
	output logic                              power_code_invalid
);

	// narrower samples would cut the threshold, shorter addresses lose the map
	if (CHANNELS < 1 || SAMPLE_W < 8 || ADDR_W < 10) begin : g_bad_params
		$error("orip_regs: unsupported parameters");
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [7:0] overrange_threshold_reg;
	logic [7:0] overrange_config_reg;
	logic       startup_done_reg;
	logic [7:0] power_profile_b_reg;
	logic [7:0] power_profile_c_reg;
	logic [7:0] power_profile_d_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			overrange_threshold_reg <= `ORIP_RST_LEVEL;
		else if (reg_wr && reg_addr == `ORIP_ADDR_LEVEL)
			overrange_threshold_reg <= reg_wdata;
	end

	// exponent and enable, upper bits held at zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			overrange_config_reg <= `ORIP_RST_SETUP;
		else if (reg_wr && reg_addr == `ORIP_ADDR_SETUP)
			overrange_config_reg <= reg_wdata & `ORIP_SETUP_WMASK;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			startup_done_reg <= 1'b0;
		else if (init_finished)
			startup_done_reg <= 1'b1;
	end

	// profile registers; reserved codes are stored as written
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			power_profile_b_reg <= `ORIP_RST_PROF_B;
			power_profile_c_reg <= `ORIP_RST_PROF_C;
			power_profile_d_reg <= `ORIP_RST_PROF_D;
		end else if (reg_wr) begin
			if (reg_addr == `ORIP_ADDR_PROF_B)
				power_profile_b_reg <= reg_wdata;
			if (reg_addr == `ORIP_ADDR_PROF_C)
				power_profile_c_reg <= reg_wdata;
			if (reg_addr == `ORIP_ADDR_PROF_D)
				power_profile_d_reg <= reg_wdata;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`ORIP_ADDR_LEVEL:   v = overrange_threshold_reg;
			`ORIP_ADDR_SETUP:   v = overrange_config_reg;
			`ORIP_ADDR_STARTUP: v = {7'h00, startup_done_reg};
			`ORIP_ADDR_PROF_B:  v = power_profile_b_reg;
			`ORIP_ADDR_PROF_C:  v = power_profile_c_reg;
			`ORIP_ADDR_PROF_D:  v = power_profile_d_reg;
			default:            v = 8'h00;
		endcase
		return v;
	endfunction

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= read_mux(reg_addr);
		end
	end

	// ------------------------------------------------------------
	// power mode decode
	// ------------------------------------------------------------
	logic all_low;
	logic all_high;
	logic b_ok;
	logic c_ok;
	logic d_ok;

	always_comb begin
		b_ok = power_profile_b_reg == `ORIP_B_LOW || power_profile_b_reg == `ORIP_B_HIGH;
		c_ok = power_profile_c_reg == `ORIP_C_LOW || power_profile_c_reg == `ORIP_C_HIGH;
		d_ok = power_profile_d_reg == `ORIP_D_LOW || power_profile_d_reg == `ORIP_D_HIGH;
		all_low = power_profile_b_reg == `ORIP_B_LOW && power_profile_c_reg == `ORIP_C_LOW
			&& power_profile_d_reg == `ORIP_D_LOW;
		all_high = power_profile_b_reg == `ORIP_B_HIGH && power_profile_c_reg == `ORIP_C_HIGH
			&& power_profile_d_reg == `ORIP_D_HIGH;
	end

	// mismatched profiles only show as mixed; the host owns consistency
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			power_mode         <= ORIP_MODE_HIGH_PERF;
			power_code_invalid <= 1'b0;
			power_code_b       <= `ORIP_RST_PROF_B;
			power_code_c       <= `ORIP_RST_PROF_C;
			power_code_d       <= `ORIP_RST_PROF_D;
		end else begin
			power_code_invalid <= !(b_ok && c_ok && d_ok);
			power_code_b       <= power_profile_b_reg;
			power_code_c       <= power_profile_c_reg;
			power_code_d       <= power_profile_d_reg;
			if (all_low)
				power_mode <= ORIP_MODE_LOW_POWER;
			else if (all_high)
				power_mode <= ORIP_MODE_HIGH_PERF;
			else
				power_mode <= ORIP_MODE_MIXED;
		end
	end

	// ------------------------------------------------------------
	// over-range detection and stretch
	// ------------------------------------------------------------
	localparam int CNT_W = 10;
	logic [2:0]       stretch_exp;
	logic [CNT_W-1:0] stretch_len;
	logic             pin_enable;
	logic [CHANNELS-1:0] chan_busy;

	assign stretch_exp = overrange_config_reg[`ORIP_SETUP_EXP_HI:`ORIP_SETUP_EXP_LO];
	assign pin_enable  = overrange_config_reg[`ORIP_SETUP_EN_BIT];
	assign stretch_len = CNT_W'(`ORIP_STRETCH_BASE) << stretch_exp;

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
			logic [CNT_W-1:0]    hold_reg;
			logic [SAMPLE_W-1:0] mag;
			logic                hit;
			assign mag = sample_mag[ch*SAMPLE_W +: SAMPLE_W];
			// at-or-above compare, full scale is 511
			assign hit = mag >= SAMPLE_W'(overrange_threshold_reg);

			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n)
					hold_reg <= '0;
				else if (sample_valid) begin
					if (hit)
						hold_reg <= stretch_len;
					else if (hold_reg != '0)
						hold_reg <= hold_reg - 1'b1;
				end
			end

			assign chan_busy[ch] = hold_reg != '0;
		end
	endgenerate

	// pins gated by enable
	// one process owns all pins, so no bit of the port has two drivers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			overrange_out <= '0;
		else
			overrange_out <= pin_enable ? chan_busy : '0;
	end

endmodule
`default_nettype wire

// ===== shared/orip_cfg.svh
`ifndef ORIP_CFG_SVH
`define ORIP_CFG_SVH
// register offsets
`define ORIP_ADDR_LEVEL    10'h211
`define ORIP_ADDR_SETUP    10'h213
`define ORIP_ADDR_STARTUP  10'h270
`define ORIP_ADDR_PROF_B   10'h29A
`define ORIP_ADDR_PROF_C   10'h29B
`define ORIP_ADDR_PROF_D   10'h29C
// reset values
`define ORIP_RST_LEVEL     8'hF2
`define ORIP_RST_SETUP     8'h07
`define ORIP_RST_PROF_B    8'h0F
`define ORIP_RST_PROF_C    8'h04
`define ORIP_RST_PROF_D    8'h1B
// setup field positions
`define ORIP_SETUP_EN_BIT  3
`define ORIP_SETUP_EXP_HI  2
`define ORIP_SETUP_EXP_LO  0
`define ORIP_SETUP_WMASK   8'h0F
// power profile codes
`define ORIP_B_LOW         8'h06
`define ORIP_B_HIGH        8'h0F
`define ORIP_C_LOW         8'h00
`define ORIP_C_HIGH        8'h04
`define ORIP_D_LOW         8'h14
`define ORIP_D_HIGH        8'h1B
// stretch base count in sampling cycles
`define ORIP_STRETCH_BASE  4
`endif

// ===== shared/orip_pkg.sv
package orip_pkg;
	typedef enum logic [1:0] {
		ORIP_MODE_HIGH_PERF,
		ORIP_MODE_LOW_POWER,
		ORIP_MODE_MIXED
	} orip_mode_type;
endpackage

// ===== sim/orip_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module orip_regs_asserts (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [9:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic [3:0] overrange_out,
	input wire logic [7:0] power_code_b
);
	logic en_reg;
	// shadow of the pin enable bit
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n) en_reg <= 1'b0;
		else if (reg_wr && reg_addr == 10'h213) en_reg <= reg_wdata[3];
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_rd(a); reg_rd && reg_addr == a; endsequence
	a_rd_answer:
		assert property (reg_rd |=> reg_rvalid) else $error("no answer");
	a_rvalid_cause:
		assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
	a_rdata_hold:
		assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("rdata moved");
	a_status_bits:
		assert property (s_rd(10'h270) |=> reg_rdata[7:1] == 7'h00) else $error("status");
	a_setup_mask:
		assert property (s_rd(10'h213) |=> reg_rdata[7:4] == 4'h0) else $error("setup");
	a_unmapped_zero:
		assert property (s_rd(10'h212) |=> reg_rdata == 8'h00) else $error("unmapped");
	a_pins_gated:
		assert property (!en_reg && !$past(en_reg) |-> overrange_out == 4'h0) else $error("pins");
	a_code_b:
		assert property (reg_wr && reg_addr == 10'h29A |-> ##2 power_code_b == $past(reg_wdata, 2))
			else $error("code b");
endmodule
bind orip_regs orip_regs_asserts u_chk (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .overrange_out(overrange_out), .power_code_b(power_code_b));
`default_nettype wire

// ===== sim/orip_host.sv
`timescale 1ns/1ns
`default_nettype none
module orip_host (
	input  wire logic       clk,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [9:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 10'h000;
		reg_wdata = 8'h00;
	end
	// released address and data lines show the inverse so a stale value never passes
	task automatic xfer(logic w, logic [9:0] a, logic [7:0] di, output logic [7:0] q);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= di;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~di;
		@(posedge clk);
		q = reg_rvalid ? reg_rdata : 8'hEE;
	endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
	import orip_pkg::*;
;
	logic          clk, arst_n, sv, init_fin, wr, rd, rv, inv;
	logic [35:0]   mag;
	logic [9:0]    ad;
	logic [7:0]    wd, rdat, cb, cc, cd;
	logic [3:0]    ovr;
	orip_mode_type mode;
	int            err_count, samples_checked;
	orip_regs dut (.clk(clk), .arst_n(arst_n), .sample_valid(sv), .sample_mag(mag),
		.init_finished(init_fin), .reg_wr(wr), .reg_rd(rd), .reg_addr(ad), .reg_wdata(wd),
		.reg_rdata(rdat), .reg_rvalid(rv), .overrange_out(ovr), .power_code_b(cb),
		.power_code_c(cc), .power_code_d(cd), .power_mode(mode), .power_code_invalid(inv));
	orip_host host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(ad), .reg_wdata(wd),
		.reg_rdata(rdat), .reg_rvalid(rv));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(string n, logic [7:0] e, s);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic t_reset();
		logic [9:0] a[6] = '{10'h211, 10'h213, 10'h270, 10'h29A, 10'h29B, 10'h29C};
		logic [7:0] v[6] = '{8'hF2, 8'h07, 8'h01, 8'h0F, 8'h04, 8'h1B};
		logic [7:0] d;
		host.xfer(1'b0, 10'h270, 8'h00, d);
		chk("init", 8'h00, d);
		for (int i = 0; i < 30 && d !== 8'h01; i++) host.xfer(1'b0, 10'h270, 8'h00, d);
		for (int i = 0; i < 6; i++) begin
			host.xfer(1'b0, a[i], 8'h00, d);
			chk("reset", v[i], d);
		end
	endtask
	task automatic t_power();
		logic [7:0] d;
		host.xfer(1'b1, 10'h29A, 8'h06, d);
		host.xfer(1'b1, 10'h29B, 8'h00, d);
		host.xfer(1'b1, 10'h29C, 8'h14, d);
		host.xfer(1'b0, 10'h29C, 8'h00, d);
		chk("prof_d", 8'h14, d);
		chk("mode", 8'(ORIP_MODE_LOW_POWER), 8'(mode));
		chk("code_c", 8'h00, cc);
		chk("code_d", 8'h14, cd);
		host.xfer(1'b1, 10'h29A, 8'h07, d);
		// mode flags settle one edge after the write lands
		@(posedge clk);
		chk("reserved", 8'h01, 8'(inv));
		chk("mixed", 8'(ORIP_MODE_MIXED), 8'(mode));
		// back to high performance before any sample is judged
		host.xfer(1'b1, 10'h29A, 8'h0F, d);
		host.xfer(1'b1, 10'h29B, 8'h04, d);
		host.xfer(1'b1, 10'h29C, 8'h1B, d);
		@(posedge clk);
		chk("high", 8'(ORIP_MODE_HIGH_PERF), 8'(mode));
		chk("valid", 8'h00, 8'(inv));
		chk("code_b", 8'h0F, cb);
		chk("code_c_hp", 8'h04, cc);
	endtask
	task automatic pulse(logic [8:0] m, output int n);
		@(posedge clk);
		mag <= {18'h0, m, 9'h0};
		@(posedge clk);
		mag <= 36'h0;
		n = 0;
		repeat (40) begin
			@(posedge clk);
			n += (ovr === 4'h2);
		end
	endtask
	task automatic t_ovr();
		logic [7:0] d;
		int n;
		host.xfer(1'b1, 10'h211, 8'h40, d);
		host.xfer(1'b1, 10'h212, 8'hFF, d);
		host.xfer(1'b1, 10'h270, 8'h00, d);
		host.xfer(1'b0, 10'h212, 8'h00, d);
		chk("unmapped", 8'h00, d);
		host.xfer(1'b0, 10'h270, 8'h00, d);
		chk("status_ro", 8'h01, d);
		for (int e = 0; e < 3; e += 2) begin
			host.xfer(1'b1, 10'h213, 8'h08 | e[7:0], d);
			pulse(9'h040, n);
			chk("stretch", 8'h01, 8'(n >= (4 << e) && n <= (4 << e) + 2));
		end
		pulse(9'h03F, n);
		chk("below", 8'h00, n[7:0]);
		// a hit only counts on a valid sampling cycle
		sv <= 1'b0;
		pulse(9'h1FF, n);
		sv <= 1'b1;
		chk("no_sample", 8'h00, n[7:0]);
		host.xfer(1'b1, 10'h213, 8'h00, d);
		pulse(9'h1FF, n);
		chk("gated", 8'h00, n[7:0]);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		arst_n = 1'b0;
		sv = 1'b1;
		init_fin = 1'b0;
		mag = 36'h0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_power();
		t_ovr();
		conclude();
	end
	initial begin
		repeat (20) @(posedge clk);
		init_fin <= 1'b1;
	end
	initial begin
		#100000;
		err_count++;
		conclude();
	end
endmodule
`default_nettype wire
